// >>> aq_delay_timer.sv
// instruction delay timer: 16-bit count behind a 5-bit prescaler
`timescale 1ns/1ps
module aq_delay_timer
  import aq_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        clear_i,
  input  wire logic        start_i,
  input  wire logic [15:0] preset_i,
  output logic             busy_o,
  output logic             done_o
);

  logic [15:0]        cnt_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic [1:0]         tail_reg;
  logic               busy_reg;
  logic               done_reg;
  logic               cnt_zero;
  logic               presc_wrap;

  assign cnt_zero   = (cnt_reg == 16'h0000);
  assign presc_wrap = (presc_reg == PRESC_LAST);

  // 32 cycles per count, then a fixed two-cycle tail
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || clear_i) begin
      cnt_reg   <= 16'h0000;
      presc_reg <= '0;
      tail_reg  <= 2'h0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start_i && !busy_reg) begin
        cnt_reg   <= preset_i;
        presc_reg <= '0;
        tail_reg  <= TMR_TAIL;
        busy_reg  <= 1'b1;
      end else if (busy_reg) begin
        if (!cnt_zero) begin
          presc_reg <= presc_reg + 1'b1;
          if (presc_wrap) begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end else if (tail_reg != 2'h1) begin
          tail_reg <= tail_reg - 2'h1;
        end else begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end

  assign busy_o = busy_reg;
  assign done_o = done_reg;

endmodule : aq_delay_timer

// >>> aq_host_model.sv
// host processor model issuing strobed accesses on the parallel register port
`timescale 1ns/1ps
module aq_host_model
  import aq_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rdata_oe_i,
  output logic             cs_n_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic [4:0]       addr_o,
  output logic             bw_o,
  output logic [15:0]      wdata_o
);
  logic [15:0] dummy;
  logic        dummy_oe;

  // idle bus from time zero
  initial begin
    {cs_n_o, rd_n_o, wr_n_o, bw_o} = 4'he;
    addr_o = 5'h00;
    wdata_o = 16'h5a5a;
  end

  // one access: strobe held two edges, answer taken at the second, then a gap
  task automatic acc(input logic w, input logic b, input logic [4:0] a,
                     input logic [15:0] d, output logic [15:0] q, output logic oe);
    @(posedge ref_clk_i);
    #2;
    cs_n_o = 1'b0;
    rd_n_o = w;
    wr_n_o = !w;
    bw_o = b;
    addr_o = a;
    wdata_o = d;
    @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    #2;
    q = rdata_i;
    oe = rdata_oe_i;
    {cs_n_o, rd_n_o, wr_n_o} = 3'h7;
    wdata_o = ~wdata_o; // released data lines must not look stable
    @(posedge ref_clk_i);
    #2;
  endtask : acc

  // write; a mask write is followed by a flag read to drop spurious pin pulses
  task automatic wr(input logic b, input logic [4:0] a, input logic [15:0] d);
    acc(1'b1, b, a, d, dummy, dummy_oe);
    if (a[4:1] == ADDR_MASK) acc(1'b0, 1'b0, 5'h14, 16'h0000, dummy, dummy_oe);
  endtask : wr
endmodule : aq_host_model

// >>> aq_intr_ctrl.sv
// interrupt flags, limit flags, delay timer and fifo dma request with parallel register port
`timescale 1ns/1ps
module aq_intr_ctrl
  import aq_pkg::*;
#(
  parameter int unsigned STBY_SETTLE_CYC = STBY_SETTLE_CYC_DEF
)
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // parallel register port
  input  wire logic        cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [4:0]  addr_i,
  input  wire logic        bus_width_select_i,
  input  wire logic [15:0] data_i,
  output logic      [15:0] data_o,
  output logic             data_oe_o,
  // external request pins
  output logic             int_n_o,
  output logic             fifo_transfer_request_o,
  // sequencer progress
  input  wire logic        instr_decode_i,
  input  wire logic [2:0]  instr_ptr_i,
  input  wire logic        pause_fetch_i,
  input  wire logic [5:0]  fifo_count_i,
  // calibration and supply events
  input  wire logic        short_cal_done_i,
  input  wire logic        full_cal_done_i,
  input  wire logic        low_supply_i,
  // watchdog comparison result
  input  wire logic        wd_cmp_valid_i,
  input  wire logic        wd_cmp_second_i,
  input  wire logic        wd_above_i,
  input  wire logic        wd_trig_above_i,
  // configuration controls
  input  wire logic        device_reset_i,
  input  wire logic        standby_i,
  // delay timer handshake with the sequencer
  input  wire logic        timer_start_i,
  output logic             timer_wait_state_o,
  output logic             timer_done_o
);

  localparam int SW = $clog2(STBY_SETTLE_CYC + 1);

  // bus strobe tracking
  logic        rd_act;
  logic        wr_act;
  logic        rd_act_reg;
  logic        wr_act_reg;
  logic        rd_start;
  logic        rd_end;
  logic        wr_start;
  logic [3:0]  word_addr;
  logic        byte_hi;
  logic        bw8;

  // address decode
  logic        hit_mask;
  logic        hit_flags;
  logic        hit_timer;
  logic        hit_limits;
  logic        hit_any;

  // read capture
  logic [15:0] sel_val;
  logic [15:0] out_val;
  logic [15:0] snap_reg;
  logic        rd_flags_reg;
  logic        rd_limits_reg;
  logic        rd_hi_reg;
  logic        rd_bw8_reg;
  logic        lane_lo;
  logic        lane_hi;
  logic [15:0] data_reg;
  logic [15:0] data_next;
  logic        oe_reg;
  logic        oe_next;

  // write lanes
  logic        we_lo;
  logic        we_hi;
  logic [7:0]  wd_lo;
  logic [7:0]  wd_hi;

  // software registers
  logic [15:0] mask_reg;
  logic [15:0] timer_reg;

  // status state
  logic [FLAG_W-1:0] flag_reg;
  logic [FLAG_W-1:0] flag_next;
  logic [FLAG_W-1:0] flag_clr;
  logic [FLAG_W-1:0] ev;
  logic [15:0]       lim_reg;
  logic [15:0]       lim_next;
  logic [15:0]       lim_clr;
  logic [15:0]       lim_set;
  logic [3:0]        lim_idx;

  // event helpers
  logic        dev_clr;
  logic        wd_cross;
  logic        ip_hit;
  logic        first_zero_reg;
  logic [4:0]  fifo_thr;
  logic        fifo_hit;
  logic        fifo_hit_reg;
  logic        fifo_empty;
  logic        stby_reg;
  logic        stby_fall;
  logic [SW-1:0] settle_reg;
  logic        settle_done;

  // output registers
  logic        dreq_reg;
  logic        dreq_next;
  logic        int_n_reg;
  logic        int_n_next;

  // strobes are synchronous; edges mark start and end of an access
  assign rd_act    = ~cs_n_i & ~rd_n_i;
  assign wr_act    = ~cs_n_i & ~wr_n_i;
  assign rd_start  = rd_act & ~rd_act_reg;
  assign rd_end    = ~rd_act & rd_act_reg;
  assign wr_start  = wr_act & ~wr_act_reg;
  assign bw8       = bus_width_select_i;
  assign word_addr = addr_i[4:1];
  assign byte_hi   = addr_i[0] & bw8;

  // word decode; in 8-bit mode bit 0 picks the byte
  assign hit_mask   = (word_addr == ADDR_MASK);
  assign hit_flags  = (word_addr == ADDR_FLAGS);
  assign hit_timer  = (word_addr == ADDR_TIMER);
  assign hit_limits = (word_addr == ADDR_LIMITS);
  assign hit_any    = hit_mask | hit_flags | hit_timer | hit_limits;

  // read mux; other addresses belong to neighbouring blocks and read zero here
  assign sel_val =
    hit_mask   ? mask_reg :
    hit_flags  ? {fifo_count_i[4:0], instr_ptr_i, flag_reg} :
    hit_timer  ? timer_reg :
    hit_limits ? lim_reg : READ_ZERO;

  // byte steering for the narrow bus
  assign out_val = !bw8    ? sel_val :
                   byte_hi ? {8'h00, sel_val[15:8]} :
                             {8'h00, sel_val[7:0]};

  // data is frozen at read start so clear-on-read only drops what was seen
  assign data_next = rd_start ? out_val : data_reg;
  assign oe_next   = rd_act & hit_any;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_act_reg    <= 1'b0;
      wr_act_reg    <= 1'b0;
      snap_reg      <= 16'h0000;
      rd_flags_reg  <= 1'b0;
      rd_limits_reg <= 1'b0;
      rd_hi_reg     <= 1'b0;
      rd_bw8_reg    <= 1'b0;
      data_reg      <= 16'h0000;
      oe_reg        <= 1'b0;
    end else begin
      rd_act_reg <= rd_act;
      wr_act_reg <= wr_act;
      data_reg   <= data_next;
      oe_reg     <= oe_next;
      if (rd_start) begin
        snap_reg      <= sel_val;
        rd_flags_reg  <= hit_flags;
        rd_limits_reg <= hit_limits;
        rd_hi_reg     <= byte_hi;
        rd_bw8_reg    <= bw8;
      end
    end
  end

  // lanes that the finished read actually returned
  assign lane_lo = ~rd_bw8_reg | ~rd_hi_reg;
  assign lane_hi = ~rd_bw8_reg | rd_hi_reg;

  // clear-on-read masks taken from the snapshot
  assign flag_clr = (rd_end && rd_flags_reg && lane_lo) ? snap_reg[7:0] : 8'h00;
  assign lim_clr  = (rd_end && rd_limits_reg) ?
                    {lane_hi ? snap_reg[15:8] : 8'h00,
                     lane_lo ? snap_reg[7:0]  : 8'h00} : 16'h0000;

  // write lanes; narrow bus carries both bytes on the low lane
  assign we_lo = wr_start & (~bw8 | ~addr_i[0]);
  assign we_hi = wr_start & (~bw8 | addr_i[0]);
  assign wd_lo = data_i[7:0];
  assign wd_hi = bw8 ? data_i[7:0] : data_i[15:8];

  // mask, match value, fifo threshold and timer preset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mask_reg  <= MASK_RST;
      timer_reg <= TIMER_RST;
    end else begin
      if (we_lo && hit_mask) begin
        mask_reg[7:0] <= wd_lo;
      end
      if (we_hi && hit_mask) begin
        mask_reg[15:8] <= wd_hi;
      end
      if (we_lo && hit_timer) begin
        timer_reg[7:0] <= wd_lo;
      end
      if (we_hi && hit_timer) begin
        timer_reg[15:8] <= wd_hi;
      end
    end
  end

  // standby behaves as a held device reset, exit starts the settle count
  assign dev_clr   = device_reset_i | standby_i;
  assign stby_fall = stby_reg & ~standby_i;

  // watchdog crossing: direction bit chooses above or below
  assign wd_cross = wd_cmp_valid_i & (wd_above_i == wd_trig_above_i);
  assign lim_idx  = {wd_cmp_second_i, instr_ptr_i}; // index is 8 * second + pointer

  // one limit bit per instruction and limit
  assign lim_set = wd_cross ? 16'(16'h0001 << lim_idx) : 16'h0000;

  // pointer match, suppressed on the first fetch of instruction zero
  assign ip_hit = instr_decode_i
                & (instr_ptr_i == mask_reg[IP_MSB:IP_LSB])
                & ~(first_zero_reg & (instr_ptr_i == 3'h0));

  // fifo threshold; a zero threshold never matches
  assign fifo_thr   = mask_reg[CNT_MSB:CNT_LSB];
  assign fifo_hit   = (fifo_count_i == {1'b0, fifo_thr}) & (fifo_thr != 5'h00);
  assign fifo_empty = (fifo_count_i == 6'h00);

  // settle delay expiry
  assign settle_done = (settle_reg == SW'(1));

  // event vector, all sources of equal weight
  assign ev[FLG_WDOG]    = wd_cross;
  assign ev[FLG_IPMATCH] = ip_hit;
  assign ev[FLG_FIFO]    = fifo_hit & ~fifo_hit_reg;
  assign ev[FLG_SCAL]    = short_cal_done_i;
  assign ev[FLG_FCAL]    = full_cal_done_i;
  assign ev[FLG_PAUSE]   = pause_fetch_i;
  assign ev[FLG_LOWSUP]  = low_supply_i;
  assign ev[FLG_STBY]    = settle_done;

  // per-flag update: set wins over a read clear, device reset beats both
  for (genvar i = 0; i < FLAG_W; i++) begin : g_flag
    assign flag_next[i] = ~dev_clr & (ev[i] | (flag_reg[i] & ~flag_clr[i]));
  end

  // limit bits follow the same priority
  assign lim_next = dev_clr ? 16'h0000 : (lim_set | (lim_reg & ~lim_clr));

  // pin is low while any enabled flag stays set
  assign int_n_next = ~|(flag_next & mask_reg[7:0]);

  // request rises with flag 2 when enabled; falls on empty fifo
  always_comb begin
    dreq_next = dreq_reg;
    if (dev_clr || fifo_empty) begin
      dreq_next = 1'b0;
    end else if (ev[FLG_FIFO] && mask_reg[FLG_FIFO] && !flag_reg[FLG_FIFO]) begin
      dreq_next = 1'b1;
    end
  end

  // flag and limit storage
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flag_reg <= 8'h00;
      lim_reg  <= 16'h0000;
    end else begin
      flag_reg <= flag_next;
      lim_reg  <= lim_next;
    end
  end

  // first-fetch tracker and fifo match edge
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || dev_clr) begin
      first_zero_reg <= 1'b1;
      fifo_hit_reg   <= 1'b0;
    end else begin
      fifo_hit_reg <= fifo_hit;
      if (instr_decode_i && instr_ptr_i == 3'h0) begin
        first_zero_reg <= 1'b0;
      end
    end
  end

  // settle counter; re-entering standby abandons it
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      stby_reg   <= 1'b0;
      settle_reg <= '0;
    end else begin
      stby_reg <= standby_i;
      if (standby_i) begin
        settle_reg <= '0;
      end else if (stby_fall) begin
        settle_reg <= SW'(STBY_SETTLE_CYC);
      end else if (settle_reg != '0) begin
        settle_reg <= settle_reg - SW'(1);
      end
    end
  end

  // pins; nothing here feeds back to stop the sequencer
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      dreq_reg  <= 1'b0;
      int_n_reg <= 1'b1;
    end else begin
      dreq_reg  <= dreq_next;
      int_n_reg <= int_n_next;
    end
  end

  // delay timer reloads the preset at every start
  aq_delay_timer u_timer (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .clear_i   (dev_clr),
    .start_i   (timer_start_i),
    .preset_i  (timer_reg),
    .busy_o    (timer_wait_state_o),
    .done_o    (timer_done_o)
  );

  assign data_o                  = data_reg;
  assign data_oe_o               = oe_reg;
  assign int_n_o                 = int_n_reg;
  assign fifo_transfer_request_o = dreq_reg;

endmodule : aq_intr_ctrl

// >>> aq_intr_ctrl_properties.sv
// checker for the register port, dma request and delay timer
`timescale 1ns/1ps
module aq_intr_ctrl_properties
  import aq_pkg::*;
#(
  parameter int unsigned STBY_SETTLE_CYC = 20
)
(
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        cs_n_i,
  input wire logic        rd_n_i,
  input wire logic [4:0]  addr_i,
  input wire logic        bus_width_select_i,
  input wire logic [15:0] data_o,
  input wire logic        data_oe_o,
  input wire logic        int_n_o,
  input wire logic        fifo_transfer_request_o,
  input wire logic [2:0]  instr_ptr_i,
  input wire logic [5:0]  fifo_count_i,
  input wire logic        device_reset_i,
  input wire logic        standby_i,
  input wire logic        timer_start_i,
  input wire logic        timer_wait_state_o,
  input wire logic        timer_done_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // read strobe decode and progress fields registered every cycle
  logic       rd_act;
  logic       mapped;
  logic [7:0] prog_q;
  assign rd_act = !cs_n_i && !rd_n_i;
  assign mapped = addr_i[4:1] inside {ADDR_MASK, ADDR_FLAGS, ADDR_TIMER, ADDR_LIMITS};
  always_ff @(posedge ref_clk_i) prog_q <= {fifo_count_i[4:0], instr_ptr_i};

  AST_OE_MAPPED: assert property ($rose(rd_act) && mapped |=> data_oe_o)
    else $error("mapped read not driven");
  AST_OE_UNMAPPED: assert property ($rose(rd_act) && !mapped |=> !data_oe_o)
    else $error("unmapped read driven");
  AST_OE_DROP: assert property (rd_n_i |=> !data_oe_o)
    else $error("bus driven after strobe");
  AST_FLAG_PROGRESS: assert property ($rose(rd_act) && addr_i[4:1] == ADDR_FLAGS &&
    !bus_width_select_i |=> data_o[15:8] == prog_q) else $error("progress field wrong");
  AST_DMA_WITH_INT: assert property ($rose(fifo_transfer_request_o) |-> !int_n_o)
    else $error("dma request without interrupt");
  AST_DMA_CAUSE: assert property ($rose(fifo_transfer_request_o) |-> $past(fifo_count_i) != 6'h00)
    else $error("dma request on empty fifo");
  AST_DMA_DROP: assert property (fifo_transfer_request_o && fifo_count_i == 6'h00
    |=> !fifo_transfer_request_o) else $error("dma request held on empty fifo");
  AST_DEV_RESET: assert property (device_reset_i
    |=> !fifo_transfer_request_o && !timer_wait_state_o) else $error("device reset ignored");
  AST_TMR_START: assert property ($rose(timer_wait_state_o) |-> $past(timer_start_i))
    else $error("timer wait without start");
  AST_TMR_MIN: assert property ($rose(timer_wait_state_o) && !device_reset_i && !standby_i
    |=> timer_wait_state_o) else $error("timer wait shorter than two");
  AST_TMR_DONE: assert property ($fell(timer_wait_state_o) && !$past(device_reset_i) &&
    !$past(standby_i) && !$past(rst_i) |-> timer_done_o) else $error("timer end without done");

  // main scenarios reached
  cover property ($rose(fifo_transfer_request_o));
  cover property (timer_done_o);
  cover property ($rose(rd_act) && addr_i[4:1] == ADDR_LIMITS && bus_width_select_i);
endmodule : aq_intr_ctrl_properties

bind aq_intr_ctrl aq_intr_ctrl_properties #(.STBY_SETTLE_CYC(STBY_SETTLE_CYC)) u_props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .addr_i(addr_i),
  .bus_width_select_i(bus_width_select_i), .data_o(data_o), .data_oe_o(data_oe_o),
  .int_n_o(int_n_o), .fifo_transfer_request_o(fifo_transfer_request_o),
  .instr_ptr_i(instr_ptr_i), .fifo_count_i(fifo_count_i), .device_reset_i(device_reset_i),
  .standby_i(standby_i), .timer_start_i(timer_start_i),
  .timer_wait_state_o(timer_wait_state_o), .timer_done_o(timer_done_o)
);

// >>> aq_intr_ctrl_tb.sv
// testbench for interrupt flags, dma request, limit flags and delay timer
`timescale 1ns/1ps
module aq_intr_ctrl_tb;
  import aq_pkg::*;
  localparam int unsigned STBY = 20;
  logic        clk, rst, cs_n, rd_n, wr_n, bw, oe, int_n, dma, busy, done, o;
  logic        dec, pause, scal, fcal, lows, wdv, wds, wda, wdt, drst, stby, tstart;
  logic [4:0]  addr, thr;
  logic [2:0]  ptr;
  logic [5:0]  cnt;
  logic [15:0] wd, rdat, q, e, mk;
  logic [15:0] lfsr = 16'h002d;
  int          miscompares, n_compared, m, i, k, n, c;

`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end

  aq_host_model host (.ref_clk_i(clk), .rdata_i(rdat), .rdata_oe_i(oe), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .bw_o(bw), .wdata_o(wd));
  aq_intr_ctrl #(.STBY_SETTLE_CYC(STBY)) dut (.ref_clk_i(clk), .rst_i(rst), .cs_n_i(cs_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr), .bus_width_select_i(bw), .data_i(wd),
    .data_o(rdat), .data_oe_o(oe), .int_n_o(int_n), .fifo_transfer_request_o(dma),
    .instr_decode_i(dec), .instr_ptr_i(ptr), .pause_fetch_i(pause), .fifo_count_i(cnt),
    .short_cal_done_i(scal), .full_cal_done_i(fcal), .low_supply_i(lows),
    .wd_cmp_valid_i(wdv), .wd_cmp_second_i(wds), .wd_above_i(wda), .wd_trig_above_i(wdt),
    .device_reset_i(drst), .standby_i(stby), .timer_start_i(tstart),
    .timer_wait_state_o(busy), .timer_done_o(done));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc

  // one event source per index; standby needs its settling time
  task automatic fire(input int i);
    @(posedge clk);
    #2;
    case (i)
      0: wdv = 1'b1;
      1: dec = 1'b1;
      2: cnt = {1'b0, thr};
      3: scal = 1'b1;
      4: fcal = 1'b1;
      5: pause = 1'b1;
      6: lows = 1'b1;
      default: stby = 1'b1;
    endcase
    cyc(1);
    {wdv, dec, scal, fcal, pause, lows, stby} = 7'h00;
    cyc(i == 7 ? STBY + 4 : 2);
  endtask : fire

  task automatic tally_and_finish();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard at 30000 cycles, far beyond the less than 1000 cycles the run needs
  initial begin
    #750000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    {rst, dec, pause, scal, fcal, lows, wdv, drst, stby, tstart} = 10'h200;
    {wds, wda, wdt} = 3'h3;
    cnt = 6'h00;
    ptr = 3'h5;
    thr = 5'h1f; // full-depth threshold corner
    repeat (12) @(posedge clk);
    #2;
    rst = 1'b0;
    host.acc(1'b0, 1'b0, 5'h12, 16'h0000, q, o);
    `CHK("mask reset", MASK_RST, q)
    host.acc(1'b0, 1'b0, 5'h06, 16'h0000, q, o);
    `CHK("unmapped oe", 1'b0, o)
    e = rnd();
    host.wr(1'b1, 5'h16, {8'h00, e[7:0]});
    host.wr(1'b1, 5'h17, {8'h00, e[15:8]});
    host.acc(1'b0, 1'b0, 5'h16, 16'h0000, q, o);
    `CHK("timer bytes", e, q)
    $display("register test done");
    // every source, once masked off and once enabled
    for (m = 0; m < 2; m++) begin
      mk = {thr, 3'h5, (m != 0) ? 8'hff : 8'h00};
      host.wr(1'b0, 5'h12, mk);
      for (i = 0; i < 8; i++) begin
        fire(i);
        `CHK("int pin", m == 0, int_n)
        if (i == 2) `CHK("dma set", m[0], dma)
        host.acc(1'b0, 1'b0, 5'h14, 16'h0000, q, o);
        `CHK("flags", {cnt[4:0], ptr, 8'h01 << i}, q)
        cnt = 6'h00;
        cyc(2);
        `CHK("dma drop", 1'b0, dma)
        host.acc(1'b0, 1'b0, 5'h14, 16'h0000, q, o);
        `CHK("flags cleared", {5'h00, ptr, 8'h00}, q)
        cyc(2);
        `CHK("int released", 1'b1, int_n)
      end
    end
    $display("source test done");
    ptr = 3'h0;
    host.wr(1'b0, 5'h12, {thr, 3'h0, 8'h02});
    for (k = 0; k < 2; k++) begin
      fire(1);
      host.acc(1'b0, 1'b0, 5'h14, 16'h0000, q, o);
      `CHK("zero match", {8'h00, 6'h00, k[0], 1'b0}, q)
    end
    fire(3);
    drst = 1'b1;
    cyc(1);
    drst = 1'b0;
    cyc(2);
    host.acc(1'b0, 1'b0, 5'h14, 16'h0000, q, o);
    `CHK("device reset", 16'h0000, q)
    host.acc(1'b0, 1'b0, 5'h12, 16'h0000, q, o);
    `CHK("mask kept", {thr, 3'h0, 8'h02}, q)
    $display("pointer and reset test done");
    // random crossings, limit flags read bytewise
    for (k = 0; k < 6; k++) begin
      e = rnd();
      {wda, wdt, wds} = e[2:0];
      ptr = e[5:3];
      fire(0);
      host.acc(1'b0, 1'b0, 5'h14, 16'h0000, q, o);
      `CHK("watchdog flag", wda == wdt, q[0])
      e = (wda == wdt) ? 16'h0001 << (8 * wds + ptr) : 16'h0000;
      host.acc(1'b0, 1'b1, 5'h1a, 16'h0000, q, o);
      `CHK("limit low", e[7:0], q[7:0])
      host.acc(1'b0, 1'b1, 5'h1b, 16'h0000, q, o);
      `CHK("limit high", e[15:8], q[7:0])
    end
    $display("limit test done");
    for (k = 0; k < 3; k++) begin
      n = (k == 0) ? 0 : rnd() % 8;
      host.wr(1'b0, 5'h16, n[15:0]);
      tstart = 1'b1;
      cyc(1);
      tstart = 1'b0;
      c = 0;
      while (busy === 1'b1 && c < 300) begin
        cyc(1);
        c++;
      end
      `CHK("wait cycles", 32 * n + 2, c)
      `CHK("timer done", 1'b1, done)
    end
    $display("timer test done");
    tally_and_finish();
  end
endmodule : aq_intr_ctrl_tb

// >>> aq_pkg.sv
// constants and register map for the acquisition interrupt, limit, timer and dma logic
// Behaviour
// - watchdog crossing above or below raises flag 0
// - pointer equal to mask match raises flag 1
// - fifo count equal to threshold raises flag 2
// - short and full calibration done raise flags 3,4
// - paused instruction fetch raises flag 5
// - low analog supply raises flag 6
// - standby exit plus settling delay raises flag 7
// - flags set regardless of mask; mask gates pin
// - zero match skips first decode of instruction zero
// - interrupts never halt the sequencer
// - flag register clears on read or device reset
// - flag register shows pointer and fifo count
// - limit register: low byte limit one, high two
// - limit register clears on read or device reset
// - 16-bit timer behind 5-bit prescaler
// - timer wait lasts 32 times N plus 2 cycles
// - timer preset is byte split and reloaded each use
// - dma request and interrupt assert together
// - dma request drops on empty; rearmed by flag read
// - registers decode at word addresses 9, a, b, d
// - device reset clears flags and restarts pointer state
// - all sources equal priority onto one pin
package aq_pkg;

  // register word addresses
  localparam logic [3:0]  ADDR_MASK     = 4'h9;
  localparam logic [3:0]  ADDR_FLAGS    = 4'ha;
  localparam logic [3:0]  ADDR_TIMER    = 4'hb;
  localparam logic [3:0]  ADDR_LIMITS   = 4'hd;

  // field positions in the mask and flag registers
  localparam int          FLAG_W        = 8;
  localparam int          FLG_WDOG      = 0;
  localparam int          FLG_IPMATCH   = 1;
  localparam int          FLG_FIFO      = 2;
  localparam int          FLG_SCAL      = 3;
  localparam int          FLG_FCAL      = 4;
  localparam int          FLG_PAUSE     = 5;
  localparam int          FLG_LOWSUP    = 6;
  localparam int          FLG_STBY      = 7;
  localparam int          IP_LSB        = 8;
  localparam int          IP_MSB        = 10;
  localparam int          CNT_LSB       = 11;
  localparam int          CNT_MSB       = 15;
  localparam int          LIM2_BASE     = 8;

  // reset values
  localparam logic [15:0] MASK_RST      = 16'h0000;
  localparam logic [15:0] TIMER_RST     = 16'h0000;
  localparam logic [15:0] READ_ZERO     = 16'h0000;

  // delay timer structure
  localparam int          PRESC_W       = 5;
  localparam logic [4:0]  PRESC_LAST    = 5'h1f;
  localparam logic [1:0]  TMR_TAIL      = 2'h2;

  // standby settling delay
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned STBY_SETTLE_MS = 10;
  localparam int unsigned STBY_SETTLE_CYC_DEF = STBY_SETTLE_MS * (CLK_HZ / 1000);

endpackage : aq_pkg
